// File: core/dgc_one_sec.sv
// One-second event source: internal 8 kHz divider or synchronised external pulse.
`timescale 1ns/1ps
module dgc_one_sec #(
    parameter int PERIODS = dgc_pkg::ONE_SEC_PERIODS
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    // Configuration.
    input wire logic i_dir_out,
    // Asynchronous inputs.
    input wire logic i_clk_8k,
    input wire logic i_pin,
    // Results.
    output logic o_tick,
    output logic o_pin_o,
    output logic o_pin_oe
);

    typedef struct packed {
        logic [1:0] sync_8k;
        logic [1:0] sync_pin;
        logic prev_8k;
        logic prev_pin;
        logic [dgc_pkg::ONE_SEC_CNT_W-1:0] cnt;
        logic pulse;
        logic tick;
        logic oe;
    } dgc_sec_state_t;

    dgc_sec_state_t r;
    dgc_sec_state_t n;
    logic edge_8k;
    logic edge_pin;
    logic wrap;

    ////////////////////////////////////////////////////////////////////////////
    // Next state.
    always_comb begin
        n = r;
        n.sync_8k = {r.sync_8k[0], i_clk_8k};
        n.sync_pin = {r.sync_pin[0], i_pin};
        n.prev_8k = r.sync_8k[1];
        n.prev_pin = r.sync_pin[1];
        edge_8k = r.sync_8k[1] && !r.prev_8k;
        edge_pin = r.sync_pin[1] && !r.prev_pin;
        wrap = edge_8k && (r.cnt == dgc_pkg::ONE_SEC_CNT_W'(PERIODS - 1));
        if (edge_8k) begin
            n.cnt = wrap ? '0 : r.cnt + 1'b1;
            n.pulse = wrap && i_dir_out;
        end
        n.oe = i_dir_out;
        n.tick = i_dir_out ? wrap : edge_pin;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign o_tick = r.tick;
    assign o_pin_o = r.pulse;
    assign o_pin_oe = r.oe;

endmodule : dgc_one_sec

// File: core/dgc_pkg.sv
// Shared constants and types of the device global control bank.
package dgc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices; the byte address is four times the index.
    localparam logic [9:0] IDX_MODE = 10'h200;
    localparam logic [9:0] IDX_PHY_IF_CTRL = 10'h201;
    localparam logic [9:0] IDX_ATM_IF_CTRL = 10'h202;
    localparam logic [9:0] IDX_STATUS = 10'h210;
    localparam logic [9:0] IDX_COUNT = 10'h211;
    localparam int ADDR_IDX_LSB = 2;
    localparam int ADDR_IDX_MSB = 11;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int MODE_MASTER_BIT = 7;
    localparam int MODE_LOGIC_BIT = 6;
    localparam int MODE_STAT_LAT_BIT = 5;
    localparam int MODE_CNTR_LAT_BIT = 4;
    localparam int MODE_IRQ_EN_BIT = 3;
    localparam int MODE_DIR_OUT_BIT = 0;
    localparam int PHY_DISABLE_BIT = 6;
    localparam int ATM_SEL_LSB = 6;
    localparam int ATM_SEL_MSB = 7;
    localparam int ATM_NARROW_BIT = 5;

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset and field codes.
    localparam logic PHY_DISABLE_RST = 1'h1;
    localparam logic [1:0] ATM_SEL_RST = 2'h3;
    localparam logic [1:0] ATM_SEL_IMA = 2'h1;
    localparam logic [1:0] ATM_SEL_TC = 2'h2;
    localparam logic [7:0] CNT_MAX = 8'hFF;

    ////////////////////////////////////////////////////////////////////////////
    // Counts and bus answers.
    localparam int ONE_SEC_PERIODS = 8000;
    localparam int ONE_SEC_CNT_W = 13;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WRITE_RESP = 3'h2,
        ST_READ_RESP = 3'h4
    } dgc_axi_state_t;

endpackage : dgc_pkg

// File: core/dgc_top.sv
// Device global control bank with its AXI4-Lite slave.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
module dgc_top #(
    parameter int ONE_SEC_PERIODS = dgc_pkg::ONE_SEC_PERIODS
) (
    // Clock and reset.
    input wire logic I_CORE_CLK,
    input wire logic I_SYS_RST,
    // AXI4-Lite write address and data.
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [11:0] I_AWADDR,
    input wire logic I_WVALID,
    output logic O_WREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    // AXI4-Lite write response.
    output logic O_BVALID,
    input wire logic I_BREADY,
    output logic [1:0] O_BRESP,
    // AXI4-Lite read.
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    input wire logic [11:0] I_ARADDR,
    output logic O_RVALID,
    input wire logic I_RREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    // Events from the device logic.
    input wire logic [7:0] I_STATUS_EVT,
    input wire logic I_COUNT_EVT,
    input wire logic I_IRQ_REQ,
    // One-second pin and 8 kHz reference.
    input wire logic I_CLK_8K,
    input wire logic I_ONE_SECOND_PIN_I,
    output logic O_ONE_SECOND_PIN_O,
    output logic O_ONE_SECOND_PIN_OE,
    output logic O_ONE_SECOND_TICK,
    // Host interrupt pin, active low, driven high or low while enabled.
    output logic O_HOST_IRQ_N_O,
    output logic O_HOST_IRQ_N_OE,
    // Convergence reset and cell-side bus control.
    output logic O_TC_RESET,
    output logic O_TC_UTOPIA_EN,
    output logic O_ATM_TRISTATE,
    output logic O_ATM_TO_IMA,
    output logic O_ATM_TO_TC,
    output logic O_IMA_NARROW,
    output logic O_TC_NARROW
);

    typedef struct packed {
        dgc_pkg::dgc_axi_state_t st;
        logic aw_got;
        logic w_got;
        logic [9:0] wr_idx;
        logic [7:0] wr_data;
        logic wr_strb;
        logic awready;
        logic wready;
        logic arready;
        logic bvalid;
        logic rvalid;
        logic [1:0] bresp;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic master_reset_hold;
        logic logic_reset_hold;
        logic status_latch_en;
        logic counter_latch_en;
        logic irq_pin_en;
        logic one_second_dir_out;
        logic cell_side_bus_disable;
        logic [1:0] atm_port_select;
        logic narrow_bus_select;
        logic [7:0] stat_acc;
        logic [7:0] stat_shown;
        logic [7:0] cnt_acc;
        logic [7:0] cnt_shown;
        logic tc_reset;
        logic irq_n_o;
        logic irq_n_oe;
        logic tc_utopia_en;
        logic atm_tristate;
        logic atm_to_ima;
        logic atm_to_tc;
        logic ima_narrow;
        logic tc_narrow;
    } dgc_state_t;

    dgc_state_t r;
    dgc_state_t n;
    logic tick;
    logic stat_clr;
    logic cnt_clr;
    logic [9:0] rd_idx;

    ////////////////////////////////////////////////////////////////////////////
    // Saturating increment of an event counter.
    function automatic logic [7:0] dgc_sat_add(input logic [7:0] val, input logic evt);
        logic [7:0] res;
        res = val;
        if (evt && (val != dgc_pkg::CNT_MAX)) begin
            res = val + 8'h01;
        end
        return res;
    endfunction : dgc_sat_add

    ////////////////////////////////////////////////////////////////////////////
    // One-second event source.
    dgc_one_sec #(
        .PERIODS(ONE_SEC_PERIODS)
    ) u_one_sec (
        .i_clk(I_CORE_CLK),
        .i_rst(I_SYS_RST),
        .i_dir_out(r.one_second_dir_out),
        .i_clk_8k(I_CLK_8K),
        .i_pin(I_ONE_SECOND_PIN_I),
        .o_tick(tick),
        .o_pin_o(O_ONE_SECOND_PIN_O),
        .o_pin_oe(O_ONE_SECOND_PIN_OE)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state.
    always_comb begin
        n = r;
        stat_clr = 1'b0;
        cnt_clr = 1'b0;
        rd_idx = I_ARADDR[dgc_pkg::ADDR_IDX_MSB:dgc_pkg::ADDR_IDX_LSB];
        case (r.st)
            dgc_pkg::ST_IDLE: begin
                if (I_AWVALID && r.awready) begin
                    n.aw_got = 1'b1;
                    n.wr_idx = I_AWADDR[dgc_pkg::ADDR_IDX_MSB:dgc_pkg::ADDR_IDX_LSB];
                end
                if (I_WVALID && r.wready) begin
                    n.w_got = 1'b1;
                    n.wr_data = I_WDATA[7:0];
                    n.wr_strb = I_WSTRB[0];
                end
                if (I_ARVALID && r.arready) begin
                    n.st = dgc_pkg::ST_READ_RESP;
                    n.rvalid = 1'b1;
                    n.rresp = dgc_pkg::RESP_OKAY;
                    n.rdata = 8'h00;
                    case (rd_idx)
                        dgc_pkg::IDX_MODE: begin
                            n.rdata[dgc_pkg::MODE_MASTER_BIT] = r.master_reset_hold;
                            n.rdata[dgc_pkg::MODE_LOGIC_BIT] = r.logic_reset_hold;
                            n.rdata[dgc_pkg::MODE_STAT_LAT_BIT] = r.status_latch_en;
                            n.rdata[dgc_pkg::MODE_CNTR_LAT_BIT] = r.counter_latch_en;
                            n.rdata[dgc_pkg::MODE_IRQ_EN_BIT] = r.irq_pin_en;
                            n.rdata[dgc_pkg::MODE_DIR_OUT_BIT] = r.one_second_dir_out;
                        end
                        dgc_pkg::IDX_PHY_IF_CTRL: begin
                            n.rdata[dgc_pkg::PHY_DISABLE_BIT] = r.cell_side_bus_disable;
                        end
                        dgc_pkg::IDX_ATM_IF_CTRL: begin
                            n.rdata[dgc_pkg::ATM_SEL_MSB:dgc_pkg::ATM_SEL_LSB] = r.atm_port_select;
                            n.rdata[dgc_pkg::ATM_NARROW_BIT] = r.narrow_bus_select;
                        end
                        dgc_pkg::IDX_STATUS: begin
                            n.rdata = r.stat_shown;
                            stat_clr = 1'b1;
                        end
                        dgc_pkg::IDX_COUNT: begin
                            n.rdata = r.cnt_shown;
                            cnt_clr = 1'b1;
                        end
                        default: begin
                            n.rresp = dgc_pkg::RESP_SLVERR;
                        end
                    endcase
                end else if (r.aw_got && r.w_got) begin
                    n.st = dgc_pkg::ST_WRITE_RESP;
                    n.aw_got = 1'b0;
                    n.w_got = 1'b0;
                    n.bvalid = 1'b1;
                    n.bresp = dgc_pkg::RESP_OKAY;
                    case (r.wr_idx)
                        dgc_pkg::IDX_MODE: begin
                            if (r.wr_strb) begin
                                n.master_reset_hold = r.wr_data[dgc_pkg::MODE_MASTER_BIT];
                                n.logic_reset_hold = r.wr_data[dgc_pkg::MODE_LOGIC_BIT];
                                n.status_latch_en = r.wr_data[dgc_pkg::MODE_STAT_LAT_BIT];
                                n.counter_latch_en = r.wr_data[dgc_pkg::MODE_CNTR_LAT_BIT];
                                n.irq_pin_en = r.wr_data[dgc_pkg::MODE_IRQ_EN_BIT];
                                n.one_second_dir_out = r.wr_data[dgc_pkg::MODE_DIR_OUT_BIT];
                            end
                        end
                        dgc_pkg::IDX_PHY_IF_CTRL: begin
                            if (r.wr_strb) begin
                                n.cell_side_bus_disable = r.wr_data[dgc_pkg::PHY_DISABLE_BIT];
                            end
                        end
                        dgc_pkg::IDX_ATM_IF_CTRL: begin
                            if (r.wr_strb) begin
                                n.atm_port_select =
                                    r.wr_data[dgc_pkg::ATM_SEL_MSB:dgc_pkg::ATM_SEL_LSB];
                                n.narrow_bus_select = r.wr_data[dgc_pkg::ATM_NARROW_BIT];
                            end
                        end
                        dgc_pkg::IDX_STATUS, dgc_pkg::IDX_COUNT: begin
                            n.bresp = dgc_pkg::RESP_OKAY;
                        end
                        default: begin
                            n.bresp = dgc_pkg::RESP_SLVERR;
                        end
                    endcase
                end
            end
            dgc_pkg::ST_WRITE_RESP: begin
                if (I_BREADY) begin
                    n.bvalid = 1'b0;
                    n.st = dgc_pkg::ST_IDLE;
                end
            end
            dgc_pkg::ST_READ_RESP: begin
                if (I_RREADY) begin
                    n.rvalid = 1'b0;
                    n.st = dgc_pkg::ST_IDLE;
                end
            end
            default: begin
                n.st = dgc_pkg::ST_IDLE;
            end
        endcase
        n.awready = (n.st == dgc_pkg::ST_IDLE) && !n.aw_got;
        n.wready = (n.st == dgc_pkg::ST_IDLE) && !n.w_got;
        n.arready = (n.st == dgc_pkg::ST_IDLE);

        // Status bits: a one-second event outranks a clearing read.
        if (r.status_latch_en) begin
            n.stat_acc = tick ? I_STATUS_EVT : (r.stat_acc | I_STATUS_EVT);
            if (tick) begin
                n.stat_shown = r.stat_acc;
            end else if (stat_clr) begin
                n.stat_shown = 8'h00;
            end
        end else begin
            n.stat_acc = 8'h00;
            n.stat_shown = (stat_clr ? 8'h00 : r.stat_shown) | I_STATUS_EVT;
        end

        // Event counter: an event in the clearing cycle is kept.
        if (r.counter_latch_en) begin
            n.cnt_acc = tick ? {7'h00, I_COUNT_EVT} : dgc_sat_add(r.cnt_acc, I_COUNT_EVT);
            if (tick) begin
                n.cnt_shown = r.cnt_acc;
            end else if (cnt_clr) begin
                n.cnt_shown = 8'h00;
            end
        end else begin
            n.cnt_acc = 8'h00;
            n.cnt_shown = dgc_sat_add(cnt_clr ? 8'h00 : r.cnt_shown, I_COUNT_EVT);
        end

        // Master reset returns every other register to its default.
        if (n.master_reset_hold) begin
            n.logic_reset_hold = 1'b0;
            n.status_latch_en = 1'b0;
            n.counter_latch_en = 1'b0;
            n.irq_pin_en = 1'b0;
            n.one_second_dir_out = 1'b0;
            n.cell_side_bus_disable = dgc_pkg::PHY_DISABLE_RST;
            n.atm_port_select = dgc_pkg::ATM_SEL_RST;
            n.narrow_bus_select = 1'b0;
            n.stat_acc = 8'h00;
            n.stat_shown = 8'h00;
            n.cnt_acc = 8'h00;
            n.cnt_shown = 8'h00;
        end

        // Registered pin and control outputs.
        n.tc_reset = n.master_reset_hold || n.logic_reset_hold;
        n.irq_n_o = !(n.irq_pin_en && I_IRQ_REQ);
        n.irq_n_oe = n.irq_pin_en;
        n.tc_utopia_en = !n.cell_side_bus_disable;
        n.atm_to_ima = (n.atm_port_select == dgc_pkg::ATM_SEL_IMA);
        n.atm_to_tc = (n.atm_port_select == dgc_pkg::ATM_SEL_TC);
        n.atm_tristate = !n.atm_to_ima && !n.atm_to_tc;
        n.ima_narrow = n.atm_to_ima ? n.narrow_bus_select : 1'b1;
        n.tc_narrow = n.atm_to_tc ? n.narrow_bus_select : 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            r <= '0;
            r.st <= dgc_pkg::ST_IDLE;
            r.cell_side_bus_disable <= dgc_pkg::PHY_DISABLE_RST;
            r.atm_port_select <= dgc_pkg::ATM_SEL_RST;
            r.tc_reset <= 1'b1;
            r.irq_n_o <= 1'b1;
            r.atm_tristate <= 1'b1;
            r.ima_narrow <= 1'b1;
            r.tc_narrow <= 1'b1;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign O_AWREADY = r.awready;
    assign O_WREADY = r.wready;
    assign O_BVALID = r.bvalid;
    assign O_BRESP = r.bresp;
    assign O_ARREADY = r.arready;
    assign O_RVALID = r.rvalid;
    assign O_RDATA = {24'h000000, r.rdata};
    assign O_RRESP = r.rresp;
    assign O_ONE_SECOND_TICK = tick;
    assign O_HOST_IRQ_N_O = r.irq_n_o;
    assign O_HOST_IRQ_N_OE = r.irq_n_oe;
    assign O_TC_RESET = r.tc_reset;
    assign O_TC_UTOPIA_EN = r.tc_utopia_en;
    assign O_ATM_TRISTATE = r.atm_tristate;
    assign O_ATM_TO_IMA = r.atm_to_ima;
    assign O_ATM_TO_TC = r.atm_to_tc;
    assign O_IMA_NARROW = r.ima_narrow;
    assign O_TC_NARROW = r.tc_narrow;

endmodule : dgc_top

// File: test/dgc_top_chk.sv
// Port-level assertions for the device global control bank.
`timescale 1ns/1ps
module dgc_top_chk #(
    parameter int ONE_SEC_PERIODS = dgc_pkg::ONE_SEC_PERIODS
) (
    // Clock and reset.
    input wire logic I_CORE_CLK,
    input wire logic I_SYS_RST,
    // Interrupt request and pin.
    input wire logic I_IRQ_REQ,
    input wire logic O_HOST_IRQ_N_O,
    input wire logic O_HOST_IRQ_N_OE,
    // Cell-side bus control.
    input wire logic O_ATM_TRISTATE,
    input wire logic O_ATM_TO_IMA,
    input wire logic O_ATM_TO_TC,
    input wire logic O_IMA_NARROW,
    input wire logic O_TC_NARROW,
    input wire logic O_TC_RESET,
    // One-second event.
    input wire logic O_ONE_SECOND_TICK,
    input wire logic O_ONE_SECOND_PIN_O,
    input wire logic O_ONE_SECOND_PIN_OE
);
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (I_SYS_RST);

    ////////////////////////////////////////////////////////////////////////////
    property p_irq_idle;
        !O_HOST_IRQ_N_OE |-> O_HOST_IRQ_N_O;
    endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("Released pin shows low.");
    property p_irq_value;
        O_HOST_IRQ_N_O == !(O_HOST_IRQ_N_OE && $past(I_IRQ_REQ));
    endproperty
    a_irq_value: assert property (p_irq_value) else $error("Interrupt pin value wrong.");
    property p_sel_onehot;
        $onehot({O_ATM_TRISTATE, O_ATM_TO_IMA, O_ATM_TO_TC});
    endproperty
    a_sel_onehot: assert property (p_sel_onehot) else $error("Port select not one-hot.");
    property p_tc_fixed;
        O_ATM_TO_IMA |-> O_TC_NARROW;
    endproperty
    a_tc_fixed: assert property (p_tc_fixed) else $error("Convergence bus not narrow.");
    property p_ima_idle;
        !O_ATM_TO_IMA |-> O_IMA_NARROW;
    endproperty
    a_ima_idle: assert property (p_ima_idle) else $error("Unselected core bus wide.");
    property p_tick_single;
        O_ONE_SECOND_TICK |=> !O_ONE_SECOND_TICK;
    endproperty
    a_tick_single: assert property (p_tick_single) else $error("Tick longer than one.");
    property p_pin_dir;
        $rose(O_ONE_SECOND_PIN_O) |-> O_ONE_SECOND_PIN_OE ##1 O_ONE_SECOND_PIN_O [*8];
    endproperty
    a_pin_dir: assert property (p_pin_dir) else $error("Pin pulse bad.");
    property p_tc_release;
        $fell(I_SYS_RST) |-> O_TC_RESET;
    endproperty
    a_tc_release: assert property (p_tc_release) else $error("Convergence reset missing.");
endmodule : dgc_top_chk

bind dgc_top dgc_top_chk #(.ONE_SEC_PERIODS(ONE_SEC_PERIODS)) chk_i (.*);

// File: test/dgc_top_tb.sv
// Self-checking bench for the device global control bank.
`timescale 1ns/1ps
module dgc_top_tb;
    localparam int PER = 4;
    localparam logic [9:0] MODE_IX = dgc_pkg::IDX_MODE;
    localparam logic [9:0] PHY_IX = dgc_pkg::IDX_PHY_IF_CTRL;
    localparam logic [9:0] ATM_IX = dgc_pkg::IDX_ATM_IF_CTRL;
    localparam logic [9:0] STS_IX = dgc_pkg::IDX_STATUS;
    localparam logic [9:0] CNT_IX = dgc_pkg::IDX_COUNT;
    localparam logic [1:0] OKAY = dgc_pkg::RESP_OKAY;
    localparam logic [1:0] SERR = dgc_pkg::RESP_SLVERR;
    logic I_CORE_CLK = 1'h0;
    logic I_CLK_8K = 1'h0;
    logic I_SYS_RST, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY;
    logic I_COUNT_EVT, I_IRQ_REQ, I_ONE_SECOND_PIN_I;
    logic [11:0] I_AWADDR, I_ARADDR;
    logic [31:0] I_WDATA, O_RDATA, rdat;
    logic [3:0] I_WSTRB;
    logic [7:0] I_STATUS_EVT;
    logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
    logic [1:0] O_BRESP, O_RRESP, bresp, rresp;
    logic O_ONE_SECOND_PIN_O, O_ONE_SECOND_PIN_OE, O_ONE_SECOND_TICK;
    logic O_HOST_IRQ_N_O, O_HOST_IRQ_N_OE, O_TC_RESET, O_TC_UTOPIA_EN;
    logic O_ATM_TRISTATE, O_ATM_TO_IMA, O_ATM_TO_TC, O_IMA_NARROW, O_TC_NARROW;
    int fails, cmp_count, ticks, k8;

    dgc_top #(.ONE_SEC_PERIODS(PER)) uut (
        .I_CORE_CLK, .I_SYS_RST, .I_AWVALID, .O_AWREADY, .I_AWADDR, .I_WVALID, .O_WREADY,
        .I_WDATA, .I_WSTRB, .O_BVALID, .I_BREADY, .O_BRESP, .I_ARVALID, .O_ARREADY,
        .I_ARADDR, .O_RVALID, .I_RREADY, .O_RDATA, .O_RRESP, .I_STATUS_EVT, .I_COUNT_EVT,
        .I_IRQ_REQ, .I_CLK_8K, .I_ONE_SECOND_PIN_I, .O_ONE_SECOND_PIN_O, .O_ONE_SECOND_PIN_OE,
        .O_ONE_SECOND_TICK, .O_HOST_IRQ_N_O, .O_HOST_IRQ_N_OE, .O_TC_RESET, .O_TC_UTOPIA_EN,
        .O_ATM_TRISTATE, .O_ATM_TO_IMA, .O_ATM_TO_TC, .O_IMA_NARROW, .O_TC_NARROW
    );

    always #2.5 I_CORE_CLK = ~I_CORE_CLK;
    always #26.3 I_CLK_8K = ~I_CLK_8K;
    always @(posedge I_CLK_8K) k8 <= k8 + 1;
    always @(posedge I_CORE_CLK) begin
        if (O_ONE_SECOND_TICK === 1'h1) begin
            ticks <= ticks + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge I_CORE_CLK);
    endtask : cyc

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        I_AWADDR <= {idx, 2'h0};
        I_WDATA <= {24'h0, d};
        I_AWVALID <= 1'h1;
        I_WVALID <= 1'h1;
        do begin
            cyc(1);
            n++;
            if (O_AWREADY === 1'h1) I_AWVALID <= 1'h0;
            if (O_WREADY === 1'h1) I_WVALID <= 1'h0;
        end while (O_BVALID !== 1'h1 && n < 100);
        chk({31'h0, O_BVALID}, 32'h1);
        bresp = O_BRESP;
    endtask : wr

    task automatic rchk(input logic [9:0] idx, input logic [7:0] exp, input logic [1:0] er);
        int n;
        n = 0;
        I_ARADDR <= {idx, 2'h0};
        I_ARVALID <= 1'h1;
        do begin
            cyc(1);
            n++;
            if (O_ARREADY === 1'h1) I_ARVALID <= 1'h0;
        end while (O_RVALID !== 1'h1 && n < 100);
        chk({31'h0, O_RVALID}, 32'h1);
        rdat = O_RDATA;
        rresp = O_RRESP;
        chk(rdat, {24'h0, exp});
        chk({30'h0, rresp}, {30'h0, er});
    endtask : rchk

    task automatic evt(input logic [7:0] s, input int n);
        I_STATUS_EVT <= s;
        I_COUNT_EVT <= 1'h1;
        cyc(n);
        I_STATUS_EVT <= 8'h0;
        I_COUNT_EVT <= 1'h0;
        cyc(1);
    endtask : evt

    task automatic sec;
        I_ONE_SECOND_PIN_I <= 1'h1;
        cyc(8);
        I_ONE_SECOND_PIN_I <= 1'h0;
        cyc(8);
    endtask : sec

    task automatic wait_tick;
        int n;
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (O_ONE_SECOND_TICK !== 1'h1 && n < 200);
        chk({31'h0, O_ONE_SECOND_TICK}, 32'h1);
    endtask : wait_tick

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_defaults;
        rchk(MODE_IX, 8'h00, OKAY);
        rchk(PHY_IX, 8'h40, OKAY);
        rchk(ATM_IX, 8'hC0, OKAY);
        rchk(10'h205, 8'h00, SERR);
        wr(10'h205, 8'h55);
        chk({30'h0, bresp}, {30'h0, SERR});
        wr(STS_IX, 8'hFF);
        chk({30'h0, bresp}, {30'h0, OKAY});
        rchk(STS_IX, 8'h00, OKAY);
        I_WSTRB <= 4'h0;
        wr(PHY_IX, 8'h00);
        I_WSTRB <= 4'hF;
        chk({30'h0, bresp}, {30'h0, OKAY});
        rchk(PHY_IX, 8'h40, OKAY);
        chk({30'h0, O_TC_UTOPIA_EN, O_ATM_TRISTATE}, 32'h1);
    endtask : t_defaults

    task automatic t_mux;
        logic [4:0] e;
        for (int c = 0; c < 4; c++) begin
            for (int w = 0; w < 2; w++) begin
                wr(ATM_IX, {c[1:0], w[0], 5'h0});
                cyc(2);
                e = {c == 0 || c == 3, c == 1, c == 2, c == 1 ? w[0] : 1'h1, c == 2 ? w[0] : 1'h1};
                chk({27'h0, O_ATM_TRISTATE, O_ATM_TO_IMA, O_ATM_TO_TC, O_IMA_NARROW,
                    O_TC_NARROW}, {27'h0, e});
                rchk(ATM_IX, {c[1:0], w[0], 5'h0}, OKAY);
            end
        end
        wr(PHY_IX, 8'h00);
        cyc(2);
        chk({31'h0, O_TC_UTOPIA_EN}, 32'h1);
        wr(PHY_IX, 8'h40);
        cyc(2);
        chk({31'h0, O_TC_UTOPIA_EN}, 32'h0);
    endtask : t_mux

    task automatic t_irq;
        I_IRQ_REQ <= 1'h1;
        cyc(3);
        chk({30'h0, O_HOST_IRQ_N_OE, O_HOST_IRQ_N_O}, 32'h1);
        wr(MODE_IX, 8'h08);
        cyc(3);
        chk({30'h0, O_HOST_IRQ_N_OE, O_HOST_IRQ_N_O}, 32'h2);
        I_IRQ_REQ <= 1'h0;
        cyc(3);
        chk({30'h0, O_HOST_IRQ_N_OE, O_HOST_IRQ_N_O}, 32'h3);
        wr(MODE_IX, 8'h00);
    endtask : t_irq

    task automatic t_unlatched;
        evt(8'h01, 3);
        evt(8'h04, 1);
        rchk(STS_IX, 8'h05, OKAY);
        rchk(STS_IX, 8'h00, OKAY);
        rchk(CNT_IX, 8'h04, OKAY);
        rchk(CNT_IX, 8'h00, OKAY);
        evt(8'h00, 260);
        rchk(CNT_IX, 8'hFF, OKAY);
    endtask : t_unlatched

    task automatic t_latched;
        int n;
        wr(MODE_IX, 8'h30);
        evt(8'h02, 3);
        rchk(CNT_IX, 8'h00, OKAY);
        n = ticks;
        sec();
        chk(ticks - n, 1);
        evt(8'h08, 2);
        rchk(CNT_IX, 8'h03, OKAY);
        rchk(CNT_IX, 8'h00, OKAY);
        rchk(STS_IX, 8'h02, OKAY);
        rchk(STS_IX, 8'h00, OKAY);
        sec();
        rchk(CNT_IX, 8'h02, OKAY);
        rchk(STS_IX, 8'h08, OKAY);
        wr(MODE_IX, 8'h00);
    endtask : t_latched

    task automatic t_internal;
        int n;
        wr(MODE_IX, 8'h01);
        cyc(3);
        chk({31'h0, O_ONE_SECOND_PIN_OE}, 32'h1);
        wait_tick();
        chk({31'h0, O_ONE_SECOND_PIN_O}, 32'h1);
        n = k8;
        wait_tick();
        chk(k8 - n, PER);
        cyc(20);
        wr(MODE_IX, 8'h00);
    endtask : t_internal

    task automatic t_resets;
        wr(PHY_IX, 8'h00);
        wr(ATM_IX, 8'h60);
        wr(MODE_IX, 8'h80);
        cyc(2);
        chk({31'h0, O_TC_RESET}, 32'h1);
        rchk(MODE_IX, 8'h80, OKAY);
        rchk(PHY_IX, 8'h40, OKAY);
        rchk(ATM_IX, 8'hC0, OKAY);
        wr(MODE_IX, 8'h00);
        cyc(2);
        chk({31'h0, O_TC_RESET}, 32'h0);
        wr(PHY_IX, 8'h00);
        wr(MODE_IX, 8'h40);
        cyc(2);
        chk({31'h0, O_TC_RESET}, 32'h1);
        rchk(PHY_IX, 8'h00, OKAY);
        rchk(MODE_IX, 8'h40, OKAY);
        wr(MODE_IX, 8'h00);
        cyc(2);
        chk({31'h0, O_TC_RESET}, 32'h0);
    endtask : t_resets

    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {I_SYS_RST, I_BREADY, I_RREADY} = 3'h7;
        {I_AWVALID, I_WVALID, I_ARVALID, I_COUNT_EVT, I_IRQ_REQ, I_ONE_SECOND_PIN_I} = 6'h0;
        {I_AWADDR, I_ARADDR, I_WDATA, I_STATUS_EVT} = 64'h0;
        I_WSTRB = 4'hF;
        cyc(3);
        I_SYS_RST <= 1'h0;
        cyc(1);
        t_defaults();
        t_mux();
        t_irq();
        t_unlatched();
        t_latched();
        t_internal();
        t_resets();
        summarize();
    end

    initial begin
        cyc(20000);
        chk(32'h0, 32'h1);
        summarize();
    end
endmodule : dgc_top_tb
